/* File: osl_shadow_loader.sv */
// shadow register loader with SECDED-checked nonvolatile blocks
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module osl_shadow_loader (
  input  wire logic                                clk,
  input  wire logic                                arst_n,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [osl_pkg::ADDR_W-1:0]          paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic                                wakeLoad,
  output logic                                     nvmReq,
  output logic      [osl_pkg::BLK_W-1:0]           nvmBlock,
  output logic      [osl_pkg::MARGIN_W-1:0]        nvmMargin,
  input  wire logic                                nvmValid,
  input  wire logic [osl_pkg::CODE_BITS-1:0]       nvmCode,
  output logic      [osl_pkg::SHADOW_BYTES*8-1:0]  shadow,
  output logic                                     loadBusy
);
  osl_pkg::osl_state_t                   state, next_state;
  logic [osl_pkg::BLK_W-1:0]             next_nvmBlock;
  logic [osl_pkg::MARGIN_W-1:0]          next_nvmMargin;
  logic [osl_pkg::MARGIN_W-1:0]          marginSel, next_marginSel;
  logic [osl_pkg::SHADOW_BYTES*8-1:0]    next_shadow;
  logic                                  singleFlag, next_singleFlag;
  logic                                  doubleFlag, next_doubleFlag;
  logic [osl_pkg::BLK_W-1:0]             correctedIdx, next_correctedIdx;
  logic [osl_pkg::BLK_W-1:0]             uncorrIdx, next_uncorrIdx;
  logic                                  wakePending, next_wakePending;
  logic [osl_pkg::DATA_BITS-1:0]         decData;
  logic                                  decSingle;
  logic                                  decDouble;
  logic                                  wrStrobe;
  logic [osl_pkg::IDX_W-1:0]             regIdx;
  logic [31:0]                           rdValue;
  logic                                  marginGo;
  logic                                  flagClear;
  logic                                  blockTaken;

  osl_apb_slave u_apb (
    .clk      (clk),
    .arst_n   (arst_n),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .rdValue  (rdValue),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .wrStrobe (wrStrobe),
    .regIdx   (regIdx)
  );

  osl_secded_dec u_dec (
    .code      (nvmCode),
    .data      (decData),
    .singleErr (decSingle),
    .doubleErr (decDouble)
  );

  function automatic logic [osl_pkg::DATA_BITS-1:0] blockWord(
    input logic [osl_pkg::SHADOW_BYTES*8-1:0] img,
    input logic [osl_pkg::BLK_W-1:0]          b
  );
    return img[int'(b)*osl_pkg::DATA_BITS +: osl_pkg::DATA_BITS];
  endfunction : blockWord

  assign nvmReq     = (state == osl_pkg::S_READ);
  assign loadBusy   = (state != osl_pkg::S_IDLE);
  assign blockTaken = nvmReq && nvmValid;
  assign marginGo   = wrStrobe && regIdx == osl_pkg::IDX_DIAG && pwdata[osl_pkg::GO_BIT];
  assign flagClear  = wrStrobe && regIdx == osl_pkg::IDX_FCLR && pwdata[osl_pkg::CLR_BIT];

  // shadow range readback plus control and status words
  always_comb begin
    rdValue = 32'h0000_0000;
    if (regIdx <= osl_pkg::IDX_LAST_SHADOW) begin
      rdValue[7:0] = shadow[int'(regIdx)*8 +: 8];
    end else begin
      unique case (regIdx)
        osl_pkg::IDX_DIAG:    rdValue[osl_pkg::MARGIN_LSB +: osl_pkg::MARGIN_W] = marginSel;
        osl_pkg::IDX_FAULT: begin
          rdValue[osl_pkg::SEC_BIT] = singleFlag;
          rdValue[osl_pkg::DED_BIT] = doubleFlag;
        end
        osl_pkg::IDX_SEC_BLK: rdValue[osl_pkg::BLK_W-1:0] = correctedIdx;
        osl_pkg::IDX_DED_BLK: rdValue[osl_pkg::BLK_W-1:0] = uncorrIdx;
        osl_pkg::IDX_STATUS:  rdValue[osl_pkg::BUSY_BIT] = loadBusy;
        default:              rdValue = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    next_state        = state;
    next_nvmBlock     = nvmBlock;
    next_nvmMargin    = nvmMargin;
    next_marginSel    = marginSel;
    next_shadow       = shadow;
    next_singleFlag   = singleFlag;
    next_doubleFlag   = doubleFlag;
    next_correctedIdx = correctedIdx;
    next_uncorrIdx    = uncorrIdx;
    next_wakePending  = wakePending;
    if (wrStrobe && regIdx == osl_pkg::IDX_DIAG) begin
      next_marginSel = pwdata[osl_pkg::MARGIN_LSB +: osl_pkg::MARGIN_W];
    end
    // software shadow writes only while idle; a load owns the image
    if (wrStrobe && regIdx <= osl_pkg::IDX_LAST_SHADOW && state == osl_pkg::S_IDLE) begin
      next_shadow[int'(regIdx)*8 +: 8] = pwdata[7:0];
    end
    // clear both flags; sets below win
    if (flagClear) begin
      next_singleFlag = 1'b0;
      next_doubleFlag = 1'b0;
    end
    if (wakeLoad) begin
      next_wakePending = 1'b1;
    end
    unique case (state)
      osl_pkg::S_IDLE: begin
        // trigger starts reload at the chosen margin
        if (marginGo) begin
          next_nvmMargin = pwdata[osl_pkg::MARGIN_LSB +: osl_pkg::MARGIN_W];
          next_state     = osl_pkg::S_DEFLT;
        end else if (wakePending || wakeLoad) begin
          next_nvmMargin   = osl_pkg::MARGIN_NORMAL;
          next_wakePending = 1'b0;
          next_state       = osl_pkg::S_DEFLT;
        end
      end
      osl_pkg::S_DEFLT: begin
        next_shadow   = osl_pkg::SHADOW_DEFAULT;
        next_nvmBlock = '0;
        next_state    = osl_pkg::S_READ;
      end
      osl_pkg::S_READ: begin
        if (nvmValid) begin
          // each block on its own result
          if (!decDouble) begin
            next_shadow[int'(nvmBlock)*osl_pkg::DATA_BITS +: osl_pkg::DATA_BITS] = decData;
          end
          if (decSingle) begin
            next_singleFlag   = 1'b1;
            next_correctedIdx = nvmBlock;
          end
          if (decDouble) begin
            next_doubleFlag = 1'b1;
            next_uncorrIdx  = nvmBlock;
          end
          // always move on to the next block, or back to idle after LAST_BLOCK
          if (nvmBlock == osl_pkg::LAST_BLOCK) begin
            next_state = osl_pkg::S_IDLE;
          end else begin
            next_nvmBlock = nvmBlock + 1'b1;
          end
        end
      end
    endcase
  end

  // wakePending resets high so the first load follows reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state        <= osl_pkg::S_IDLE;
      nvmBlock     <= '0;
      nvmMargin    <= osl_pkg::MARGIN_NORMAL;
      marginSel    <= osl_pkg::MARGIN_NORMAL;
      shadow       <= osl_pkg::SHADOW_DEFAULT;
      singleFlag   <= 1'b0;
      doubleFlag   <= 1'b0;
      correctedIdx <= '0;
      uncorrIdx    <= '0;
      wakePending  <= 1'b1;
    end else begin
      state        <= next_state;
      nvmBlock     <= next_nvmBlock;
      nvmMargin    <= next_nvmMargin;
      marginSel    <= next_marginSel;
      shadow       <= next_shadow;
      singleFlag   <= next_singleFlag;
      doubleFlag   <= next_doubleFlag;
      correctedIdx <= next_correctedIdx;
      uncorrIdx    <= next_uncorrIdx;
      wakePending  <= next_wakePending;
    end
  end

  sequence s_block_single;
    blockTaken && decSingle;
  endsequence

  sequence s_block_double;
    blockTaken && decDouble;
  endsequence

  a_margin_start: assert property (
    @(posedge clk) disable iff (!arst_n)
    (state == osl_pkg::S_IDLE && marginGo)
      |=> state == osl_pkg::S_DEFLT ##1 (nvmReq && nvmBlock == '0
          && nvmMargin == $past(pwdata[osl_pkg::MARGIN_LSB +: osl_pkg::MARGIN_W], 2)))
    else $error("margin trigger did not start a reload");

  a_defaults_first: assert property (
    @(posedge clk) disable iff (!arst_n)
    state == osl_pkg::S_DEFLT |=> shadow == osl_pkg::SHADOW_DEFAULT)
    else $error("defaults not written before blocks");

  a_clean_load: assert property (
    @(posedge clk) disable iff (!arst_n)
    (blockTaken && !decSingle && !decDouble)
      |=> blockWord(shadow, $past(nvmBlock)) == $past(decData))
    else $error("clean block not loaded unchanged");

  a_sec_record: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_block_single |=> singleFlag && correctedIdx == $past(nvmBlock)
      && blockWord(shadow, $past(nvmBlock)) == $past(decData))
    else $error("single error not corrected and recorded");

  a_ded_record: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_block_double |=> doubleFlag && uncorrIdx == $past(nvmBlock))
    else $error("double error not recorded");

  a_ded_noload: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_block_double |=> blockWord(shadow, $past(nvmBlock))
      == blockWord($past(shadow), $past(nvmBlock)))
    else $error("double error block was loaded");

  a_block_advance: assert property (
    @(posedge clk) disable iff (!arst_n)
    (blockTaken && nvmBlock != osl_pkg::LAST_BLOCK)
      |=> nvmReq && nvmBlock == $past(nvmBlock) + 1'b1)
    else $error("loader did not move to next block");

  a_flag_clear: assert property (
    @(posedge clk) disable iff (!arst_n)
    (flagClear && !blockTaken) |=> !singleFlag && !doubleFlag)
    else $error("flags not cleared");

  a_set_wins: assert property (
    @(posedge clk) disable iff (!arst_n)
    (flagClear && blockTaken && decSingle) |=> singleFlag [*2])
    else $error("flag set lost against clear");
endmodule : osl_shadow_loader

/* File: osl_pkg.sv */
// constants and types shared by the shadow loader files
package osl_pkg;
  localparam int SHADOW_BYTES = 48;
  localparam int DATA_BITS    = 64;
  localparam int CODE_BITS    = 72;
  localparam int SYN_BITS     = 7;
  localparam int BLK_W        = 3;
  localparam int MARGIN_W     = 3;
  localparam int IDX_W        = 8;
  localparam int ADDR_W       = 12;

  localparam logic [BLK_W-1:0]    LAST_BLOCK    = 3'h5;
  localparam logic [MARGIN_W-1:0] MARGIN_NORMAL = 3'h0;
  // hardware defaults of the shadow range, byte 0 in the low bits
  localparam logic [SHADOW_BYTES*8-1:0] SHADOW_DEFAULT = {SHADOW_BYTES{8'h00}};

  // register word indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LAST_SHADOW = 8'h2F;
  localparam logic [IDX_W-1:0] IDX_DIAG        = 8'h30;
  localparam logic [IDX_W-1:0] IDX_FAULT       = 8'h31;
  localparam logic [IDX_W-1:0] IDX_SEC_BLK     = 8'h32;
  localparam logic [IDX_W-1:0] IDX_DED_BLK     = 8'h33;
  localparam logic [IDX_W-1:0] IDX_FCLR        = 8'h34;
  localparam logic [IDX_W-1:0] IDX_STATUS      = 8'h35;

  // field positions
  localparam int MARGIN_LSB = 0;
  localparam int GO_BIT     = 3;
  localparam int SEC_BIT    = 0;
  localparam int DED_BIT    = 1;
  localparam int CLR_BIT    = 0;
  localparam int BUSY_BIT   = 0;

  typedef enum logic [1:0] {S_IDLE, S_DEFLT, S_READ} osl_state_t;

  function automatic logic isParityPos(input int pos);
    return (pos & (pos - 1)) == 0;
  endfunction : isParityPos
endpackage : osl_pkg

/* File: osl_secded_dec.sv */
// (72,64) single-correct double-detect decoder, combinational
`timescale 1ns/1ps
module osl_secded_dec (
  input  wire logic [osl_pkg::CODE_BITS-1:0] code,
  output logic      [osl_pkg::DATA_BITS-1:0] data,
  output logic                               singleErr,
  output logic                               doubleErr
);
  logic [osl_pkg::SYN_BITS-1:0]  syn;
  logic                          par;
  logic [osl_pkg::CODE_BITS-1:0] fixed;
  int                            j;

  always_comb begin
    syn   = '0;
    par   = 1'b0;
    j     = 0;
    data  = '0;
    for (int i = 0; i < osl_pkg::CODE_BITS; i++) begin
      if (code[i]) begin
        syn = syn ^ osl_pkg::SYN_BITS'(i);
        par = ~par;
      end
    end
    singleErr = par && (int'(syn) < osl_pkg::CODE_BITS);
    doubleErr = (!par && syn != '0) || (par && int'(syn) >= osl_pkg::CODE_BITS);
    fixed = code;
    if (singleErr) begin
      fixed[syn] = ~fixed[syn];
    end
    for (int i = 1; i < osl_pkg::CODE_BITS; i++) begin
      if (!osl_pkg::isParityPos(i)) begin
        data[j] = fixed[i];
        j = j + 1;
      end
    end
  end
endmodule : osl_secded_dec

/* File: osl_apb_slave.sv */
// APB slave front end: decode, zero-wait ready, registered read data
`timescale 1ns/1ps
module osl_apb_slave (
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [osl_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               rdValue,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           wrStrobe,
  output logic      [osl_pkg::IDX_W-1:0] regIdx
);
  logic        mapped;
  logic [31:0] next_prdata;

  assign regIdx = paddr[osl_pkg::IDX_W+1:2];
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[osl_pkg::ADDR_W-1:osl_pkg::IDX_W+2] == 2'h0)
                  && (regIdx <= osl_pkg::IDX_STATUS);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  // unmapped writes are dropped, flagged by pslverr
  assign wrStrobe = psel && penable && pwrite && mapped;

  // read data captured in the setup cycle so it stands as a flop output
  always_comb begin
    next_prdata = prdata;
    if (psel && !penable) begin
      next_prdata = (mapped && !pwrite) ? rdValue : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end
endmodule : osl_apb_slave

/* File: osl_nvm_model.sv */
// behavioural nonvolatile memory answering block requests
`timescale 1ns/1ps
module osl_nvm_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        nvmReq,
  input  wire logic [2:0]  nvmBlock,
  input  wire logic [3:0]  latency,
  output logic             nvmValid,
  output logic      [71:0] nvmCode
);
  logic [71:0] mem [8];
  logic [3:0]  waitCnt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nvmValid <= 1'b0;
      nvmCode  <= '0;
      waitCnt  <= 4'h0;
    end else if (nvmReq && !nvmValid && waitCnt >= latency) begin
      nvmValid <= 1'b1;
      nvmCode  <= mem[nvmBlock];
      waitCnt  <= 4'h0;
    end else begin
      // idle bus toggles so a stale word never matches
      nvmValid <= 1'b0;
      nvmCode  <= ~nvmCode;
      waitCnt  <= (nvmReq && !nvmValid) ? waitCnt + 4'h1 : 4'h0;
    end
  end
endmodule : osl_nvm_model

/* File: osl_shadow_loader_tb.sv */
// self-checking bench for the shadow loader
`timescale 1ns/1ps
module osl_shadow_loader_tb;
  logic         clk;
  logic         arst_n;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         wakeLoad;
  logic         nvmReq;
  logic [2:0]   nvmBlock;
  logic [2:0]   nvmMargin;
  logic         nvmValid;
  logic [71:0]  nvmCode;
  logic [383:0] shadow;
  logic         loadBusy;
  logic [3:0]   latency;
  logic [63:0]  dat [6];
  logic [71:0]  flip [6];
  logic [31:0]  rd;
  logic         rdErr;
  int           err_count;
  int           checked;

  osl_shadow_loader dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wakeLoad(wakeLoad), .nvmReq(nvmReq), .nvmBlock(nvmBlock),
    .nvmMargin(nvmMargin), .nvmValid(nvmValid), .nvmCode(nvmCode), .shadow(shadow),
    .loadBusy(loadBusy));
  osl_nvm_model mem_u (.clk(clk), .arst_n(arst_n), .nvmReq(nvmReq), .nvmBlock(nvmBlock),
    .latency(latency), .nvmValid(nvmValid), .nvmCode(nvmCode));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic summarize;
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chkReg(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chkReg

  task automatic chkImg(input logic [383:0] e);
    checked++;
    if (shadow !== e) begin
      err_count++;
      $display("BAD shadow expected %h seen %h", e, shadow);
    end
  endtask : chkImg

  // independent encoder: data ascending, parity at 0 and powers of two
  function automatic logic [71:0] enc(input logic [63:0] d);
    logic [71:0] c;
    int          k;
    c = '0;
    k = 0;
    for (int i = 3; i < 72; i++)
      if ((i & (i - 1)) != 0) begin
        c[i] = d[k];
        k++;
      end
    for (int p = 1; p < 72; p = p * 2)
      for (int i = p + 1; i < 72; i++)
        if ((i & p) != 0) c[p] = c[p] ^ c[i];
    c[0] = ^c;
    return c;
  endfunction : enc

  function automatic logic [383:0] img(input logic [5:0] skip);
    logic [383:0] r;
    r = osl_pkg::SHADOW_DEFAULT;
    for (int b = 0; b < 6; b++)
      if (!skip[b]) r[64*b +: 64] = dat[b];
    return r;
  endfunction : img

  task automatic setMem;
    for (int b = 0; b < 6; b++)
      mem_u.mem[b] = enc(dat[b]) ^ flip[b];
  endtask : setMem

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      summarize();
    end
    rd = prdata;
    rdErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic waitIdle;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (loadBusy !== 1'b0 && n < 400);
    if (loadBusy !== 1'b0) begin
      err_count++;
      summarize();
    end
  endtask : waitIdle

  task automatic chkRead(input string n, input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    chkReg(n, e, rd);
  endtask : chkRead

  task automatic s_reset;
    for (int b = 0; b < 6; b++) flip[b] = '0;
    flip[1] = 72'h1 << 5;
    flip[3] = 72'h1 << 40;
    flip[4] = (72'h1 << 10) | (72'h1 << 20);
    setMem();
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    waitIdle();
    chkImg(img(6'b010000));
    chkRead("flags", osl_pkg::IDX_FAULT, 32'h3);
    chkRead("secblk", osl_pkg::IDX_SEC_BLK, 32'h3);
    chkRead("dedblk", osl_pkg::IDX_DED_BLK, 32'h4);
    chkRead("byte8", 8'h08, {24'h0, dat[1][7:0]});
  endtask : s_reset

  task automatic s_clear;
    apb(1'b1, osl_pkg::IDX_FCLR, 32'h1);
    chkRead("flags", osl_pkg::IDX_FAULT, 32'h0);
    chkRead("secblk", osl_pkg::IDX_SEC_BLK, 32'h3);
  endtask : s_clear

  task automatic s_margin;
    flip[1] = '0;
    flip[3] = '0;
    flip[4] = '0;
    flip[0] = (72'h1 << 3) | (72'h1 << 6);
    flip[2] = 72'h1;
    flip[5] = 72'h1 << 71;
    setMem();
    latency <= 4'h3;
    apb(1'b1, 8'h00, 32'hAA);
    chkRead("byte0", 8'h00, 32'hAA);
    apb(1'b1, osl_pkg::IDX_DIAG, 32'hD);
    @(negedge clk);
    chkReg("margin", 32'h5, {29'h0, nvmMargin});
    chkRead("busy", osl_pkg::IDX_STATUS, 32'h1);
    // shadow write while loading must be dropped; block 0 keeps its default
    apb(1'b1, 8'h00, 32'h77);
    waitIdle();
    chkRead("idle", osl_pkg::IDX_STATUS, 32'h0);
    chkImg(img(6'b000001));
    chkRead("flags", osl_pkg::IDX_FAULT, 32'h3);
    chkRead("secblk", osl_pkg::IDX_SEC_BLK, 32'h5);
    chkRead("dedblk", osl_pkg::IDX_DED_BLK, 32'h0);
    chkRead("diag", osl_pkg::IDX_DIAG, 32'h5);
  endtask : s_margin

  task automatic s_wake;
    for (int b = 0; b < 6; b++) flip[b] = '0;
    setMem();
    latency <= 4'h0;
    apb(1'b1, osl_pkg::IDX_FCLR, 32'h1);
    @(posedge clk);
    wakeLoad <= 1'b1;
    @(posedge clk);
    wakeLoad <= 1'b0;
    @(negedge clk);
    chkReg("margin", 32'h0, {29'h0, nvmMargin});
    waitIdle();
    chkImg(img(6'b000000));
    chkRead("flags", osl_pkg::IDX_FAULT, 32'h0);
  endtask : s_wake

  task automatic s_race;
    flip[0] = 72'h1 << 9;
    setMem();
    apb(1'b1, osl_pkg::IDX_DIAG, 32'h8);
    // clear lands on the edge that takes block 0
    apb(1'b1, osl_pkg::IDX_FCLR, 32'h1);
    waitIdle();
    chkImg(img(6'b000000));
    chkRead("flags", osl_pkg::IDX_FAULT, 32'h1);
    chkRead("secblk", osl_pkg::IDX_SEC_BLK, 32'h0);
  endtask : s_race

  task automatic s_rereset;
    for (int b = 0; b < 6; b++) flip[b] = '0;
    flip[2] = (72'h1 << 12) | (72'h1 << 13);
    setMem();
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    chkReg("busy", 32'h0, {31'h0, loadBusy});
    chkReg("req", 32'h0, {31'h0, nvmReq});
    chkImg(osl_pkg::SHADOW_DEFAULT);
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chkReg("busy", 32'h1, {31'h0, loadBusy});
    @(negedge clk);
    chkReg("req", 32'h1, {31'h0, nvmReq});
    chkReg("block", 32'h0, {29'h0, nvmBlock});
    waitIdle();
    chkImg(img(6'b000100));
    chkRead("flags", osl_pkg::IDX_FAULT, 32'h2);
    chkRead("dedblk", osl_pkg::IDX_DED_BLK, 32'h2);
  endtask : s_rereset

  task automatic s_unmapped;
    apb(1'b0, 8'h36, 32'h0);
    chkReg("rdata", 32'h0, rd);
    chkReg("slverr", 32'h1, {31'h0, rdErr});
  endtask : s_unmapped

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    wakeLoad = 1'b0;
    latency = 4'h0;
    err_count = 0;
    checked = 0;
    for (int b = 0; b < 6; b++)
      dat[b] = 64'hA5C3_0F1E_7B29_D486 + 64'(b) * 64'h1111_1111_1111_1111;
    s_reset();
    s_clear();
    s_margin();
    s_wake();
    s_race();
    s_rereset();
    s_unmapped();
    summarize();
  end
endmodule : osl_shadow_loader_tb
